// ===== smrs_top.sv
// Stop mode and reset sequencer top level.
// Assumes synchronous inputs from the core, interrupt logic and reset pin.
// Function
// - Stop instruction enters STOP standby mode.
// - Pending unmasked request releases stop at once.
// - STOP halts oscillator and core clock.
// - Latches held; watchdog, memory, detector stop.
// - Timer A counts only cascaded, external clock.
// - Timer B counts only on external clock.
// - Bit buffer runs on external timer B match.
// - Unmasked interrupt ends stop, vectors if enabled.
// - Interrupts disabled: continue after stop instruction.
// - Key return interrupt always ends stop, vectors.
// - Reset out of stop waits stabilization first.
// - Pin, watchdog, power-on-clear resets act alike.
// - Fetch starts from the reset vector.
// - Pins high impedance in reset and wait.
// - Pin release runs after stabilization wait.
// - Watchdog reset clears itself, then waits.
// - Stop held during reset, ports high impedance.
// - Reset values for status, ports, interrupt flags.
// - Timers and watchdog control registers cleared.
// - Power-on-clear flags read 04H after that reset.
// - Program counter undefined through reset and wait.
// - Selector picks 2^12, 2^15 or 2^17 cycles.
`timescale 1ns/100ps
module smrs_top (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic watchdog_overflow,
  input wire logic power_on_clear_detect,
  input wire logic stop_instr,
  input wire logic [7:0] irq_request_flags_in,
  input wire logic [7:0] irq_mask_flags_in,
  input wire logic global_irq_enable,
  input wire logic key_return_irq,
  input wire logic [2:0] stabilization_time_select_wdata,
  input wire logic stabilization_time_select_we,
  input wire logic timer_a_cascaded,
  input wire logic timer_b_ext_clock,
  input wire logic timer_b_match_irq,
  output logic osc_enable,
  output logic core_clk_enable,
  output logic pins_hiz,
  output logic watchdog_run,
  output logic nv_memory_run,
  output logic low_voltage_detector_run,
  output logic key_return_run,
  output logic timer_a_run,
  output logic timer_b_run,
  output logic bit_buffer_run,
  output logic resume_next,
  output logic resume_vector,
  output logic fetch_reset_vector,
  output logic [15:0] reset_vector_addr,
  output logic pc_valid,
  output logic core_reset,
  output logic [2:0] stabilization_time_select,
  output logic [7:0] program_status_word_rst,
  output logic [7:0] port_latch_rst,
  output logic [7:0] port_mode_rst,
  output logic [7:0] irq_request_flags_rst,
  output logic [7:0] irq_mask_flags_rst,
  output logic [7:0] timer_ctrl_rst,
  output logic [7:0] power_on_clear_flags
);
  smrs_pkg::smrs_state_e state_reg, state_next;
  smrs_pkg::smrs_resume_e resume_reg, resume_next_v;
  logic [2:0] stabilization_time_select_reg;
  logic [7:0] pocf_reg;
  logic any_reset;
  logic unmasked_pending;
  logic wake_irq;
  logic in_stop;
  logic [4:0] irq_exponent;
  logic osc_en_next, core_en_next, hiz_next;
  logic pulse_next, vec_next, fetch_next;
  smrs_wait_if wif ();

  smrs_wait_cnt smrs_wait_cnt_i (
    .sys_clk(sys_clk),
    .reset(reset),
    .wif(wif)
  );

  // All three reset sources merge into one request; only the power-on-clear flag tells them apart.
  assign any_reset = !reset_pin_n || watchdog_overflow || power_on_clear_detect;
  assign unmasked_pending = |(irq_request_flags_in & ~irq_mask_flags_in);
  assign wake_irq = unmasked_pending || key_return_irq;
  assign in_stop = (state_reg == smrs_pkg::ST_STOP);
  assign irq_exponent = (stabilization_time_select_reg == smrs_pkg::STABILIZATION_TIME_SELECT_2P12) ? 5'(smrs_pkg::EXP_2P12) :
                        (stabilization_time_select_reg == smrs_pkg::STABILIZATION_TIME_SELECT_2P15) ? 5'(smrs_pkg::EXP_2P15) :
                        5'(smrs_pkg::EXP_2P17);
  assign wif.start = (state_next == smrs_pkg::ST_WAIT_IRQ || state_next == smrs_pkg::ST_WAIT_RST) &&
                     (state_reg != state_next);
  assign wif.exponent = (state_next == smrs_pkg::ST_WAIT_RST) ? 5'(smrs_pkg::EXP_RESET) : irq_exponent;

  always_comb begin
    state_next = state_reg;
    resume_next_v = resume_reg;
    case (state_reg)
      smrs_pkg::ST_RUN: begin
        if (any_reset) begin
          state_next = smrs_pkg::ST_RST;
        end else if (stop_instr) begin
          state_next = smrs_pkg::ST_STOP;
          resume_next_v = smrs_pkg::RES_NEXT;
        end
      end
      smrs_pkg::ST_STOP: begin
        if (any_reset) begin
          state_next = smrs_pkg::ST_STOP;
        end else if (resume_reg == smrs_pkg::RES_RESET) begin
          state_next = smrs_pkg::ST_WAIT_RST;
        end else if (key_return_irq) begin
          state_next = smrs_pkg::ST_WAIT_IRQ;
          resume_next_v = smrs_pkg::RES_VECTOR;
        end else if (unmasked_pending) begin
          state_next = smrs_pkg::ST_WAIT_IRQ;
          resume_next_v = global_irq_enable ? smrs_pkg::RES_VECTOR : smrs_pkg::RES_NEXT;
        end
      end
      smrs_pkg::ST_RST: begin
        if (!any_reset) begin
          state_next = smrs_pkg::ST_WAIT_RST;
        end
      end
      smrs_pkg::ST_WAIT_IRQ: begin
        if (any_reset) begin
          state_next = smrs_pkg::ST_RST;
        end else if (wif.done) begin
          state_next = smrs_pkg::ST_RUN;
        end
      end
      smrs_pkg::ST_WAIT_RST: begin
        if (any_reset) begin
          state_next = smrs_pkg::ST_RST;
        end else if (wif.done) begin
          state_next = smrs_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = smrs_pkg::ST_RST;
      end
    endcase
    if (in_stop && any_reset) begin
      resume_next_v = smrs_pkg::RES_RESET;
    end
  end

  assign osc_en_next = (state_next != smrs_pkg::ST_STOP);
  assign core_en_next = (state_next == smrs_pkg::ST_RUN);
  // Pins float during reset, the wait after it, and stop while reset is held.
  assign hiz_next = (state_next == smrs_pkg::ST_RST) || (state_next == smrs_pkg::ST_WAIT_RST) ||
                    (state_next == smrs_pkg::ST_STOP && any_reset);
  assign pulse_next = (state_next == smrs_pkg::ST_RUN) && (state_reg == smrs_pkg::ST_WAIT_IRQ);
  assign vec_next = pulse_next && (resume_reg == smrs_pkg::RES_VECTOR);
  assign fetch_next = (state_next == smrs_pkg::ST_RUN) && (state_reg == smrs_pkg::ST_WAIT_RST);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= smrs_pkg::ST_RST;
      resume_reg <= smrs_pkg::RES_RESET;
    end else begin
      state_reg <= state_next;
      resume_reg <= resume_next_v;
    end
  end

  // The selector keeps its value across stop; prohibited codes are ignored on write.
  always_ff @(posedge sys_clk) begin
    if (reset || any_reset) begin
      stabilization_time_select_reg <= smrs_pkg::STABILIZATION_TIME_SELECT_RST[2:0];
    end else if (stabilization_time_select_we &&
                 (stabilization_time_select_wdata == smrs_pkg::STABILIZATION_TIME_SELECT_2P12 ||
                  stabilization_time_select_wdata == smrs_pkg::STABILIZATION_TIME_SELECT_2P15 ||
                  stabilization_time_select_wdata == smrs_pkg::STABILIZATION_TIME_SELECT_2P17)) begin
      stabilization_time_select_reg <= stabilization_time_select_wdata;
    end
  end

  // The flag keeps the power-on-clear cause until the next reset of another kind.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pocf_reg <= smrs_pkg::POCF_RST;
    end else if (power_on_clear_detect) begin
      pocf_reg <= smrs_pkg::POCF_POC;
    end else if (any_reset) begin
      pocf_reg <= smrs_pkg::POCF_RST;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      osc_enable <= 1'b1;
      core_clk_enable <= 1'b0;
      pins_hiz <= 1'b1;
      watchdog_run <= 1'b0;
      nv_memory_run <= 1'b0;
      low_voltage_detector_run <= 1'b0;
      key_return_run <= 1'b0;
      timer_a_run <= 1'b0;
      timer_b_run <= 1'b0;
      bit_buffer_run <= 1'b0;
      resume_next <= 1'b0;
      resume_vector <= 1'b0;
      fetch_reset_vector <= 1'b0;
      pc_valid <= 1'b0;
      core_reset <= 1'b1;
    end else begin
      osc_enable <= osc_en_next;
      core_clk_enable <= core_en_next;
      pins_hiz <= hiz_next;
      watchdog_run <= osc_en_next;
      nv_memory_run <= osc_en_next;
      low_voltage_detector_run <= osc_en_next;
      key_return_run <= !osc_en_next;
      timer_a_run <= osc_en_next || (timer_a_cascaded && timer_b_ext_clock);
      timer_b_run <= osc_en_next || timer_b_ext_clock;
      bit_buffer_run <= osc_en_next || (timer_b_ext_clock && timer_b_match_irq);
      resume_next <= pulse_next && !vec_next;
      resume_vector <= vec_next;
      fetch_reset_vector <= fetch_next;
      pc_valid <= core_en_next;
      core_reset <= (state_next == smrs_pkg::ST_RST) || (state_next == smrs_pkg::ST_WAIT_RST) ||
                    (state_next == smrs_pkg::ST_STOP && resume_next_v == smrs_pkg::RES_RESET);
    end
  end

  // These are reset images applied by the core while core_reset is high; all but the selector and the power-on-clear flags are constant.
  always_ff @(posedge sys_clk) begin
    reset_vector_addr <= smrs_pkg::RESET_VECTOR_ADDR;
    stabilization_time_select <= stabilization_time_select_reg;
    program_status_word_rst <= smrs_pkg::PSW_RST;
    port_latch_rst <= smrs_pkg::LATCH_RST;
    port_mode_rst <= smrs_pkg::PMODE_RST;
    irq_request_flags_rst <= smrs_pkg::IRQ_REQ_RST;
    irq_mask_flags_rst <= smrs_pkg::IRQ_MASK_RST;
    timer_ctrl_rst <= smrs_pkg::ZERO_RST;
    power_on_clear_flags <= pocf_reg;
  end

  property p_stop_no_core;
    @(posedge sys_clk) disable iff (reset) (state_reg == smrs_pkg::ST_STOP) |-> !osc_enable && !core_clk_enable;
  endproperty
  a_stop_no_core: assert property (p_stop_no_core) else $error("core clock runs in stop");

  property p_enter_stop;
    @(posedge sys_clk) disable iff (reset)
      (state_reg == smrs_pkg::ST_RUN && stop_instr && !any_reset) |=> (state_reg == smrs_pkg::ST_STOP);
  endproperty
  a_enter_stop: assert property (p_enter_stop) else $error("stop not entered");

  property p_masked_stays;
    @(posedge sys_clk) disable iff (reset)
      (in_stop && !any_reset && !wake_irq && resume_reg != smrs_pkg::RES_RESET) |=> in_stop;
  endproperty
  a_masked_stays: assert property (p_masked_stays) else $error("masked request left stop");

  property p_key_wakes;
    @(posedge sys_clk) disable iff (reset)
      (in_stop && key_return_irq && !any_reset && resume_reg != smrs_pkg::RES_RESET)
      |=> (state_reg == smrs_pkg::ST_WAIT_IRQ) && (resume_reg == smrs_pkg::RES_VECTOR);
  endproperty
  a_key_wakes: assert property (p_key_wakes) else $error("key return did not vector");

  property p_hiz_in_reset;
    @(posedge sys_clk) disable iff (reset) (state_reg == smrs_pkg::ST_RST) |-> pins_hiz;
  endproperty
  a_hiz_in_reset: assert property (p_hiz_in_reset) else $error("pins driven in reset");

  property p_stop_held_reset;
    @(posedge sys_clk) disable iff (reset) (in_stop && any_reset) |=> in_stop && pins_hiz;
  endproperty
  a_stop_held_reset: assert property (p_stop_held_reset) else $error("stop lost under reset");

  property p_no_run_in_wait;
    @(posedge sys_clk) disable iff (reset) (state_reg == smrs_pkg::ST_WAIT_RST) |-> !pc_valid;
  endproperty
  a_no_run_in_wait: assert property (p_no_run_in_wait) else $error("pc valid during wait");

  property p_fetch_after_wait;
    @(posedge sys_clk) disable iff (reset)
      (state_reg == smrs_pkg::ST_WAIT_RST && wif.done && !any_reset) |=> fetch_reset_vector && core_clk_enable;
  endproperty
  a_fetch_after_wait: assert property (p_fetch_after_wait) else $error("no reset vector fetch");

  property p_pocf;
    @(posedge sys_clk) disable iff (reset) power_on_clear_detect |=> ##1 (power_on_clear_flags == smrs_pkg::POCF_POC);
  endproperty
  a_pocf: assert property (p_pocf) else $error("power-on-clear flag wrong");

  property p_resume_next;
    @(posedge sys_clk) disable iff (reset)
      (state_reg == smrs_pkg::ST_WAIT_IRQ && wif.done && !any_reset && resume_reg == smrs_pkg::RES_NEXT)
      |=> resume_next && !resume_vector;
  endproperty
  a_resume_next: assert property (p_resume_next) else $error("no resume at next instruction");

  property p_resume_vector;
    @(posedge sys_clk) disable iff (reset)
      (state_reg == smrs_pkg::ST_WAIT_IRQ && wif.done && !any_reset && resume_reg == smrs_pkg::RES_VECTOR)
      |=> resume_vector && !resume_next;
  endproperty
  a_resume_vector: assert property (p_resume_vector) else $error("no vectored resume");

  property p_wait_gated;
    @(posedge sys_clk) disable iff (reset) (state_reg == smrs_pkg::ST_WAIT_IRQ) |-> !core_clk_enable;
  endproperty
  a_wait_gated: assert property (p_wait_gated) else $error("core clock runs during wait");
endmodule // smrs_top

// ===== smrs_pkg.sv
// Constants and types for the stop mode and reset sequencer.
// Assumes a single 125 MHz system clock domain.
package smrs_pkg;
  localparam logic [2:0] STABILIZATION_TIME_SELECT_2P12 = 3'h0;
  localparam logic [2:0] STABILIZATION_TIME_SELECT_2P15 = 3'h2;
  localparam logic [2:0] STABILIZATION_TIME_SELECT_2P17 = 3'h4;
  localparam logic [7:0] STABILIZATION_TIME_SELECT_RST = 8'h04;
  localparam int EXP_2P12 = 12;
  localparam int EXP_2P15 = 15;
  localparam int EXP_2P17 = 17;
  localparam int EXP_RESET = 15;
  localparam int CNT_W = 18;
  localparam logic [7:0] PSW_RST = 8'h02;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] PMODE_RST = 8'hFF;
  localparam logic [7:0] IRQ_REQ_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST = 8'hFF;
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam logic [7:0] POCF_RST = 8'h00;
  localparam logic [7:0] POCF_POC = 8'h04;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;
  localparam int EXT_RESET_MIN_NS = 10000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int EXT_RESET_MIN_CYC = (EXT_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {ST_RUN, ST_STOP, ST_RST, ST_WAIT_IRQ, ST_WAIT_RST} smrs_state_e;
  typedef enum logic [1:0] {RES_NEXT, RES_VECTOR, RES_RESET} smrs_resume_e;
endpackage

// ===== smrs_wait_if.sv
// Interface between the sequencer and its stabilization wait counter.
// Assumes both ends share sys_clk.
`timescale 1ns/100ps
interface smrs_wait_if;
  logic start;
  logic [4:0] exponent;
  logic done;
  modport ctrl (output start, output exponent, input done);
  modport cnt (input start, input exponent, output done);
endinterface // smrs_wait_if

// ===== smrs_wait_cnt.sv
// Oscillation stabilization wait counter.
// Assumes the counter sees the restarted oscillator as sys_clk.
`timescale 1ns/100ps
module smrs_wait_cnt (
  input wire logic sys_clk,
  input wire logic reset,
  smrs_wait_if.cnt wif
);
  logic [smrs_pkg::CNT_W-1:0] count_reg;
  logic busy_reg;
  logic done_reg;
  logic [smrs_pkg::CNT_W-1:0] limit;
  assign limit = (smrs_pkg::CNT_W)'(({{(smrs_pkg::CNT_W-1){1'b0}}, 1'b1} << wif.exponent) - 1'b1);
  assign wif.done = done_reg;
  always_ff @(posedge sys_clk) begin
    if (reset || wif.start) begin
      count_reg <= '0;
      busy_reg <= wif.start && !reset;
      done_reg <= 1'b0;
    end else if (busy_reg) begin
      count_reg <= count_reg + 1'b1;
      busy_reg <= (count_reg != limit);
      done_reg <= (count_reg == limit);
    end else begin
      done_reg <= 1'b0;
    end
  end
endmodule // smrs_wait_cnt

// ===== smrs_pin_model.sv
// Model of the external reset source that drives the reset pin.
// Assumes req is a one-cycle pulse on sys_clk; the pin idles high through its pull-up.
`timescale 1ns/100ps
module smrs_pin_model (
  input wire logic sys_clk,
  input wire logic req,
  output logic reset_pin_n
);
  int cnt = 0;
  // The low phase is never cut short, so the device always sees a legal pulse width.
  always @(posedge sys_clk) begin
    if (req) begin
      cnt <= smrs_pkg::EXT_RESET_MIN_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign reset_pin_n = (cnt == 0);
endmodule // smrs_pin_model

// ===== smrs_top_tb.sv
// Self-checking testbench for the stop mode and reset sequencer.
// Assumes the design package and the reset pin model are compiled first.
`timescale 1ns/100ps
module smrs_top_tb;
  logic sys_clk = 1'b0, reset = 1'b1, reset_pin_n, watchdog_overflow = 1'b0, power_on_clear_detect = 1'b0;
  logic stop_instr = 1'b0, global_irq_enable = 1'b0, key_return_irq = 1'b0, stabilization_time_select_we = 1'b0;
  logic timer_a_cascaded = 1'b0, timer_b_ext_clock = 1'b0, timer_b_match_irq = 1'b0, pin_req = 1'b0;
  logic [7:0] irq_request_flags_in = 8'h00, irq_mask_flags_in = 8'hFF;
  logic [2:0] stabilization_time_select_wdata = 3'h0, stabilization_time_select;
  logic osc_enable, core_clk_enable, pins_hiz, watchdog_run, nv_memory_run, low_voltage_detector_run;
  logic key_return_run, timer_a_run, timer_b_run, bit_buffer_run, resume_next, resume_vector;
  logic fetch_reset_vector, pc_valid, core_reset;
  logic [15:0] reset_vector_addr;
  logic [7:0] program_status_word_rst, port_latch_rst, port_mode_rst, irq_request_flags_rst;
  logic [7:0] irq_mask_flags_rst, timer_ctrl_rst, power_on_clear_flags;
  int n_fail = 0;
  int comparisons = 0;
  int cyc;

  smrs_pin_model smrs_pin_model_i (.sys_clk, .req(pin_req), .reset_pin_n);

  smrs_top smrs_top_i (.sys_clk, .reset, .reset_pin_n, .watchdog_overflow, .power_on_clear_detect,
    .stop_instr, .irq_request_flags_in, .irq_mask_flags_in, .global_irq_enable, .key_return_irq,
    .stabilization_time_select_wdata, .stabilization_time_select_we, .timer_a_cascaded,
    .timer_b_ext_clock, .timer_b_match_irq, .osc_enable, .core_clk_enable, .pins_hiz, .watchdog_run,
    .nv_memory_run, .low_voltage_detector_run, .key_return_run, .timer_a_run, .timer_b_run,
    .bit_buffer_run, .resume_next, .resume_vector, .fetch_reset_vector, .reset_vector_addr, .pc_valid,
    .core_reset, .stabilization_time_select, .program_status_word_rst, .port_latch_rst, .port_mode_rst,
    .irq_request_flags_rst, .irq_mask_flags_rst, .timer_ctrl_rst, .power_on_clear_flags);

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [2:0] ev();
    return {fetch_reset_vector, resume_vector, resume_next};
  endfunction

  // Pulses are sampled on the falling edge, where the registered outputs have settled.
  task automatic wait_ev(input int lim);
    cyc = 0;
    do begin
      @(negedge sys_clk);
      cyc++;
    end while (cyc < lim && ev() === 3'h0);
  endtask

  // A power-on-clear pulse right after release, then a watchdog overflow that restarts the wait.
  task automatic t_boot();
    power_on_clear_detect <= 1'b1;
    @(posedge sys_clk);
    power_on_clear_detect <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({pins_hiz, pc_valid}, 2'h2);
    chk({program_status_word_rst, port_latch_rst, port_mode_rst, irq_request_flags_rst}, 32'h0200FF00);
    chk({irq_mask_flags_rst, timer_ctrl_rst, power_on_clear_flags, 5'h00, stabilization_time_select},
      32'hFF000404);
    repeat (1000) @(posedge sys_clk);
    watchdog_overflow <= 1'b1;
    @(posedge sys_clk);
    watchdog_overflow <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({pins_hiz, core_reset, pc_valid, power_on_clear_flags}, 11'h600);
    wait_ev(40000);
    chk(ev(), 3'h4);
    chk(cyc >= 2 ** smrs_pkg::EXP_RESET, 1);
    chk(reset_vector_addr, 16'h0000);
    repeat (2) @(negedge sys_clk);
    chk({pins_hiz, core_reset, pc_valid, core_clk_enable}, 4'h3);
  endtask

  task automatic t_sel();
    @(posedge sys_clk);
    stabilization_time_select_we <= 1'b1;
    @(posedge sys_clk);
    stabilization_time_select_wdata <= 3'h3;
    @(posedge sys_clk);
    stabilization_time_select_we <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(stabilization_time_select, 3'h0);
  endtask

  // Mode 0 wakes by unmasking, 1 by key return, 2 has the request pending at entry.
  task automatic t_stop(input logic ie, input int mode, input logic [2:0] exp);
    @(posedge sys_clk);
    global_irq_enable <= ie;
    timer_a_cascaded <= ie;
    timer_b_ext_clock <= 1'b1;
    timer_b_match_irq <= 1'b1;
    irq_request_flags_in <= 8'h01;
    irq_mask_flags_in <= (mode == 2) ? 8'h00 : 8'h01;
    stop_instr <= 1'b1;
    @(posedge sys_clk);
    stop_instr <= 1'b0;
    if (mode != 2) begin
      repeat (20) @(negedge sys_clk);
      chk({osc_enable, core_clk_enable, watchdog_run, nv_memory_run, low_voltage_detector_run, key_return_run,
        timer_a_run, timer_b_run, bit_buffer_run}, {6'h01, ie, 2'h3});
      @(posedge sys_clk);
      if (mode == 1) begin
        key_return_irq <= 1'b1;
      end else begin
        irq_mask_flags_in <= 8'h00;
      end
    end
    wait_ev(4200);
    chk({ev(), core_clk_enable}, {exp, 1'b1});
    chk(cyc >= 4096, 1);
    @(posedge sys_clk);
    key_return_irq <= 1'b0;
    irq_mask_flags_in <= 8'hFF;
    irq_request_flags_in <= 8'h00;
  endtask

  task automatic t_rst_stop();
    @(posedge sys_clk);
    stop_instr <= 1'b1;
    @(posedge sys_clk);
    stop_instr <= 1'b0;
    repeat (5) @(posedge sys_clk);
    pin_req <= 1'b1;
    power_on_clear_detect <= 1'b1;
    @(posedge sys_clk);
    pin_req <= 1'b0;
    repeat (100) @(negedge sys_clk);
    chk({pins_hiz, osc_enable, core_reset}, 3'h5);
    // The detector outlasts the pin, so it is the last reset cause and its flag must survive.
    repeat (smrs_pkg::EXT_RESET_MIN_CYC) @(posedge sys_clk);
    power_on_clear_detect <= 1'b0;
    wait_ev(40000);
    chk(ev(), 3'h4);
    chk(cyc >= 2 ** smrs_pkg::EXP_RESET, 1);
    chk(power_on_clear_flags, 8'h04);
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    t_boot();
    t_sel();
    t_stop(1'b1, 0, 3'h2);
    t_stop(1'b0, 0, 3'h1);
    t_stop(1'b0, 1, 3'h2);
    t_stop(1'b1, 2, 3'h2);
    t_rst_stop();
    give_verdict();
  end
endmodule // smrs_top_tb
